/* src/bsc_strap_loader.sv */
`timescale 1ns/1ps
`include "bsc_defs.svh"

module bsc_strap_loader #(
  parameter int unsigned TIMEOUT_CYC = 32'(`BSC_TIMEOUT_CYC),
  parameter int unsigned TBL_INIT_CYC = `BSC_TBL_INIT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] strap_config_pins,
  input wire logic [7:0] port_tx_enable_straps,
  input wire logic global_control_reg_init_complete,
  input wire logic eeprom_load_done,
  input wire logic [`BSC_N_PORTS-1:0] port_activity,
  input wire logic [`BSC_N_SM-1:0] sm_nonidle,
  input wire logic timeout_irq_sel,
  output logic straps_valid_ff,
  output bsc_pkg::bsc_mgmt_t mgmt_mode_ff,
  output logic managed_ff,
  output logic serial_debounce_en_ff,
  output logic [2:0] serial_dev_id_ff,
  output logic eeprom_load_req_ff,
  output logic hotswap_en_ff,
  output logic [7:0] module_type_ff,
  output logic power_save_en_ff,
  output logic [`BSC_N_PORTS-1:0] port_power_save_ff,
  output logic timeout_mon_en_ff,
  output logic timeout_reset_req_ff,
  output logic timeout_irq_ff,
  output logic table_init_busy_ff,
  output logic switch_enable_ff,
  output logic vlan_port_based_ff,
  output logic learn_zero_mac_ff,
  output logic rsvd_mc_drop_ff,
  output logic rsvd_mc_to_cpu_ff,
  output logic ip_mc_en_ff,
  output logic trunk_en_ff,
  output logic mirror_en_ff,
  output logic [15:0] age_time_s_ff,
  output logic [9:0] fc_frame_thresh_ff,
  output logic [7:0] weighted_random_drop_pct_ff,
  output logic flood_ctrl_en_ff,
  output logic [10:0] frame_min_ff,
  output logic [10:0] frame_max_ff,
  output logic pad_short_ff,
  output logic std_preamble_ff,
  output logic strict_prio_ff,
  output logic stp_forwarding_ff,
  output logic learn_en_ff,
  output logic fe_rmii_mode_ff,
  output logic uplink_mii_mode_ff,
  output logic autoneg_fd_fc_ff,
  output logic [8:0] fe_buf_ff,
  output logic [8:0] fe_thresh_ff,
  output logic [8:0] uplink_buf_ff,
  output logic [8:0] uplink_thresh_ff,
  output logic irq_en_all_ff,
  output logic learn_report_en_ff,
  output logic stats_en_ff,
  output logic [6:0] cpu_speed_m_ff,
  output logic cpu_full_duplex_fc_ff,
  output logic [3:0] cpu_hdr_pad_ff,
  output logic heartbeat_en_ff
);

  logic [15:0] strap_ff;
  logic [7:0] txen_strap_ff;
  bsc_pkg::bsc_state_t state_ff;
  bsc_pkg::bsc_state_t nxt_state;
  logic [31:0] tbl_cnt_ff;
  bsc_pkg::bsc_mgmt_t mode_dec;
  logic serial_dec;
  logic unmanaged_dec;

  function automatic bsc_pkg::bsc_mgmt_t decode_mode(input logic [2:0] f);
    bsc_pkg::bsc_mgmt_t m;
    case (f)
      3'h0: m = bsc_pkg::MGMT_PAR16;
      3'h1: m = bsc_pkg::MGMT_PAR8;
      3'h2: m = bsc_pkg::MGMT_SER_MII;
      3'h3: m = bsc_pkg::MGMT_SER_ONLY;
      default: m = bsc_pkg::MGMT_UNMANAGED;
    endcase
    return m;
  endfunction : decode_mode

  // First edge after release takes the straps; async reset only loads constants
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_ff <= 16'h0000;
      txen_strap_ff <= 8'h00;
      straps_valid_ff <= 1'b0;
    end else if (!straps_valid_ff) begin
      strap_ff <= strap_config_pins;
      txen_strap_ff <= port_tx_enable_straps;
      straps_valid_ff <= 1'b1;
    end
  end

  assign mode_dec = decode_mode(strap_ff[`BSC_F_MODE_HI:`BSC_F_MODE_LO]);
  assign unmanaged_dec = (mode_dec == bsc_pkg::MGMT_UNMANAGED);
  assign serial_dec = (mode_dec == bsc_pkg::MGMT_SER_MII) || (mode_dec == bsc_pkg::MGMT_SER_ONLY) || unmanaged_dec;

  // Decoded strap options, loaded once when the straps are known
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mgmt_mode_ff <= bsc_pkg::MGMT_UNMANAGED;
      managed_ff <= 1'b0;
      serial_debounce_en_ff <= 1'b0;
      serial_dev_id_ff <= 3'h0;
      hotswap_en_ff <= 1'b0;
      module_type_ff <= 8'h00;
      power_save_en_ff <= 1'b0;
      timeout_mon_en_ff <= 1'b0;
    end else if (state_ff == bsc_pkg::ST_DECODE) begin
      mgmt_mode_ff <= mode_dec;
      managed_ff <= !unmanaged_dec;
      serial_debounce_en_ff <= serial_dec && strap_ff[`BSC_B_DEBOUNCE];
      serial_dev_id_ff <= serial_dec ? strap_ff[`BSC_F_DEVID_HI:`BSC_F_DEVID_LO] : 3'h0;
      hotswap_en_ff <= strap_ff[`BSC_B_HOTSWAP];
      module_type_ff <= strap_ff[`BSC_B_HOTSWAP] ? txen_strap_ff : 8'h00;
      power_save_en_ff <= strap_ff[`BSC_B_PWR_SAVE];
      timeout_mon_en_ff <= strap_ff[`BSC_B_TIMEOUT];
    end
  end

  // Start-up sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bsc_pkg::ST_SAMPLE: begin
        if (straps_valid_ff) begin
          nxt_state = bsc_pkg::ST_DECODE;
        end
      end
      bsc_pkg::ST_DECODE: begin
        nxt_state = unmanaged_dec ? bsc_pkg::ST_RUN : bsc_pkg::ST_TBL_INIT;
      end
      bsc_pkg::ST_TBL_INIT: begin
        if (tbl_cnt_ff == TBL_INIT_CYC - 32'h1) begin
          nxt_state = bsc_pkg::ST_WAIT_HOST;
        end
      end
      bsc_pkg::ST_WAIT_HOST: begin
        if (global_control_reg_init_complete) begin
          nxt_state = bsc_pkg::ST_RUN;
        end
      end
      bsc_pkg::ST_RUN: begin
        nxt_state = bsc_pkg::ST_RUN;
      end
      default: begin
        nxt_state = bsc_pkg::ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= bsc_pkg::ST_SAMPLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Table initialisation dwell; the host must not configure before it ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbl_cnt_ff <= 32'h0;
      table_init_busy_ff <= 1'b0;
    end else begin
      tbl_cnt_ff <= (state_ff == bsc_pkg::ST_TBL_INIT) ? tbl_cnt_ff + 32'h1 : 32'h0;
      table_init_busy_ff <= (nxt_state == bsc_pkg::ST_TBL_INIT);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_enable_ff <= 1'b0;
    end else begin
      switch_enable_ff <= (nxt_state == bsc_pkg::ST_RUN);
    end
  end

  // EEPROM load request stands until the loader reports completion
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eeprom_load_req_ff <= 1'b0;
    end else if (state_ff == bsc_pkg::ST_DECODE) begin
      eeprom_load_req_ff <= unmanaged_dec && !strap_ff[`BSC_B_EEPROM_DIS];
    end else if (eeprom_load_done) begin
      eeprom_load_req_ff <= 1'b0;
    end
  end

  // Reset-default configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vlan_port_based_ff <= 1'b1;
      learn_zero_mac_ff <= 1'b0;
      rsvd_mc_drop_ff <= 1'b1;
      ip_mc_en_ff <= 1'b0;
      trunk_en_ff <= 1'b0;
      mirror_en_ff <= 1'b0;
      age_time_s_ff <= `BSC_AGE_S;
      fc_frame_thresh_ff <= `BSC_FC_FRAMES;
      weighted_random_drop_pct_ff <= `BSC_WEIGHTED_RANDOM_DROP_PCT;
      flood_ctrl_en_ff <= 1'b0;
      frame_min_ff <= `BSC_FRM_MIN;
      frame_max_ff <= `BSC_FRM_MAX;
      pad_short_ff <= 1'b1;
      std_preamble_ff <= 1'b1;
      strict_prio_ff <= 1'b1;
      stp_forwarding_ff <= 1'b1;
      learn_en_ff <= 1'b1;
      fe_rmii_mode_ff <= 1'b1;
      uplink_mii_mode_ff <= 1'b1;
      autoneg_fd_fc_ff <= 1'b1;
      fe_buf_ff <= `BSC_FE_BUF;
      fe_thresh_ff <= `BSC_FE_THR;
      uplink_buf_ff <= `BSC_UP_BUF;
      uplink_thresh_ff <= `BSC_UP_THR;
    end else begin
      vlan_port_based_ff <= 1'b1;
      learn_zero_mac_ff <= 1'b0;
      rsvd_mc_drop_ff <= 1'b1;
      ip_mc_en_ff <= 1'b0;
      trunk_en_ff <= 1'b0;
      mirror_en_ff <= 1'b0;
      age_time_s_ff <= `BSC_AGE_S;
      fc_frame_thresh_ff <= `BSC_FC_FRAMES;
      weighted_random_drop_pct_ff <= `BSC_WEIGHTED_RANDOM_DROP_PCT;
      flood_ctrl_en_ff <= 1'b0;
      frame_min_ff <= `BSC_FRM_MIN;
      frame_max_ff <= `BSC_FRM_MAX;
      pad_short_ff <= 1'b1;
      std_preamble_ff <= 1'b1;
      strict_prio_ff <= 1'b1;
      stp_forwarding_ff <= 1'b1;
      learn_en_ff <= 1'b1;
      fe_rmii_mode_ff <= 1'b1;
      uplink_mii_mode_ff <= 1'b1;
      autoneg_fd_fc_ff <= 1'b1;
      fe_buf_ff <= `BSC_FE_BUF;
      fe_thresh_ff <= `BSC_FE_THR;
      uplink_buf_ff <= `BSC_UP_BUF;
      uplink_thresh_ff <= `BSC_UP_THR;
    end
  end

  // Defaults that only apply when a host manages the device
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsvd_mc_to_cpu_ff <= 1'b0;
      irq_en_all_ff <= 1'b0;
      learn_report_en_ff <= 1'b0;
      stats_en_ff <= 1'b0;
      cpu_speed_m_ff <= 7'h00;
      cpu_full_duplex_fc_ff <= 1'b0;
      cpu_hdr_pad_ff <= 4'h0;
      heartbeat_en_ff <= 1'b0;
    end else if (state_ff == bsc_pkg::ST_DECODE) begin
      rsvd_mc_to_cpu_ff <= !unmanaged_dec;
      irq_en_all_ff <= !unmanaged_dec;
      learn_report_en_ff <= 1'b0;
      stats_en_ff <= 1'b0;
      cpu_speed_m_ff <= unmanaged_dec ? 7'h00 : `BSC_CPU_SPEED_M;
      cpu_full_duplex_fc_ff <= !unmanaged_dec;
      cpu_hdr_pad_ff <= unmanaged_dec ? 4'h0 : `BSC_CPU_PAD;
      heartbeat_en_ff <= 1'b0;
    end
  end

  // Per-port MAC power saving
  genvar p;
  generate
    for (p = 0; p < `BSC_N_PORTS; p++) begin : g_port
      logic [9:0] idle_ff;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          idle_ff <= 10'h000;
          port_power_save_ff[p] <= 1'b0;
        end else begin
          if (!power_save_en_ff || port_activity[p]) begin
            idle_ff <= 10'h000;
          end else if (idle_ff != `BSC_IDLE_CYC) begin
            idle_ff <= idle_ff + 10'h001;
          end
          port_power_save_ff[p] <= power_save_en_ff && !port_activity[p] && (idle_ff == `BSC_IDLE_CYC);
        end
      end
    end
  endgenerate

  bsc_stuck_monitor #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_stuck (
    .clk(clk),
    .rst(rst),
    .mon_en(timeout_mon_en_ff),
    .irq_sel(timeout_irq_sel),
    .sm_nonidle(sm_nonidle),
    .stuck_reset_req(timeout_reset_req_ff),
    .stuck_irq(timeout_irq_ff)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_capture;
    !straps_valid_ff ##1 straps_valid_ff;
  endsequence

  sequence s_decoded;
    state_ff == bsc_pkg::ST_DECODE ##1 1'b1;
  endsequence

  a_strap_capture: assert property ($rose(straps_valid_ff) |-> strap_ff == $past(strap_config_pins)
    && txen_strap_ff == $past(port_tx_enable_straps))
    else $error("strap value not taken at release");
  a_strap_hold: assert property (straps_valid_ff |=> $stable(strap_ff) && $stable(txen_strap_ff))
    else $error("latched straps changed after capture");
  // Field codes with the top bit set all fall back to unmanaged
  a_mode_unmanaged: assert property (s_decoded |-> strap_ff[3] == (mgmt_mode_ff == bsc_pkg::MGMT_UNMANAGED))
    else $error("unmanaged decode wrong");
  a_mode_parallel: assert property (s_decoded |-> (strap_ff[3:1] == 3'h1) == (mgmt_mode_ff == bsc_pkg::MGMT_PAR8))
    else $error("8-bit parallel decode wrong");
  a_mode_serial_mii: assert property (s_decoded |-> (strap_ff[3:1] == 3'h2) == (mgmt_mode_ff == bsc_pkg::MGMT_SER_MII))
    else $error("serial with MII decode wrong");
  a_debounce_gate: assert property (serial_debounce_en_ff |-> strap_ff[0] && mgmt_mode_ff[1])
    else $error("debounce enabled outside serial mode or with strap low");
  a_devid_gate: assert property (!mgmt_mode_ff[1] |-> serial_dev_id_ff == 3'h0)
    else $error("device id set in parallel mode");
  a_eeprom_gate: assert property (eeprom_load_req_ff |-> !strap_ff[7] && mgmt_mode_ff == bsc_pkg::MGMT_UNMANAGED)
    else $error("eeprom load requested outside unmanaged mode");
  a_hotswap_gate: assert property (!hotswap_en_ff |-> module_type_ff == 8'h00)
    else $error("module type reported without hotswap");
  a_pwr_wake: assert property (port_activity[0] |=> !port_power_save_ff[0])
    else $error("port stayed in power save despite activity");
  a_unmanaged_run: assert property (s_capture ##1 unmanaged_dec |-> ##[0:1] switch_enable_ff)
    else $error("unmanaged device did not start switching");
  a_managed_hold: assert property ($rose(switch_enable_ff) && managed_ff |-> $past(global_control_reg_init_complete))
    else $error("managed device switched before init complete");
  a_tbl_before_run: assert property (table_init_busy_ff |-> !switch_enable_ff)
    else $error("switching while tables initialise");
  a_defaults: assert property (s_capture |-> age_time_s_ff == 16'h012C
    && fc_frame_thresh_ff == 10'h060 && frame_max_ff == 11'h5F2 && uplink_buf_ff == 9'h180)
    else $error("reset defaults wrong");
  a_managed_cpu: assert property (s_decoded |-> managed_ff == (cpu_hdr_pad_ff == 4'h8) && !stats_en_ff)
    else $error("managed CPU port defaults wrong");

endmodule : bsc_strap_loader

/* pkg/bsc_defs.svh */
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH

`define BSC_CLK_PERIOD_NS 10

// Strap field positions
`define BSC_B_DEBOUNCE 0
`define BSC_F_MODE_HI 3
`define BSC_F_MODE_LO 1
`define BSC_F_DEVID_HI 6
`define BSC_F_DEVID_LO 4
`define BSC_B_EEPROM_DIS 7
`define BSC_B_HOTSWAP 9
`define BSC_B_PWR_SAVE 11
`define BSC_B_TIMEOUT 12

`define BSC_N_PORTS 10
`define BSC_N_SM 8

// Timing
`define BSC_TIMEOUT_S 5
`define BSC_TIMEOUT_CYC (64'd`BSC_TIMEOUT_S * 64'd1000000000 / 64'd`BSC_CLK_PERIOD_NS)
`define BSC_TBL_INIT_US 100
`define BSC_TBL_INIT_CYC ((`BSC_TBL_INIT_US * 1000 + `BSC_CLK_PERIOD_NS - 1) / `BSC_CLK_PERIOD_NS)
`define BSC_IDLE_US 10
`define BSC_IDLE_CYC 10'((`BSC_IDLE_US * 1000) / `BSC_CLK_PERIOD_NS)

// Reset-default switch configuration
`define BSC_AGE_S 16'h012C
`define BSC_FC_FRAMES 10'h060
`define BSC_WEIGHTED_RANDOM_DROP_PCT 8'h00
`define BSC_FRM_MIN 11'h040
`define BSC_FRM_MAX 11'h5F2
`define BSC_FE_BUF 9'h060
`define BSC_FE_THR 9'h030
`define BSC_UP_BUF 9'h180
`define BSC_UP_THR 9'h0C0
`define BSC_CPU_SPEED_M 7'h64
`define BSC_CPU_PAD 4'h8

`endif

/* pkg/bsc_pkg.sv */
package bsc_pkg;

  typedef enum logic [2:0] {
    MGMT_PAR16 = 3'h0,
    MGMT_PAR8 = 3'h1,
    MGMT_SER_MII = 3'h2,
    MGMT_SER_ONLY = 3'h3,
    MGMT_UNMANAGED = 3'h7
  } bsc_mgmt_t;

  typedef enum logic [4:0] {
    ST_SAMPLE = 5'h01,
    ST_DECODE = 5'h02,
    ST_TBL_INIT = 5'h04,
    ST_WAIT_HOST = 5'h08,
    ST_RUN = 5'h10
  } bsc_state_t;

endpackage : bsc_pkg

/* src/bsc_stuck_monitor.sv */
`timescale 1ns/1ps
`include "bsc_defs.svh"

module bsc_stuck_monitor #(
  parameter int unsigned TIMEOUT_CYC = 32'(`BSC_TIMEOUT_CYC)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mon_en,
  input wire logic irq_sel,
  input wire logic [`BSC_N_SM-1:0] sm_nonidle,
  output logic stuck_reset_req,
  output logic stuck_irq
);

  logic [`BSC_N_SM-1:0] hit;

  // One saturating dwell counter per watched state machine
  genvar g;
  generate
    for (g = 0; g < `BSC_N_SM; g++) begin : g_sm
      logic [31:0] dwell_ff;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          dwell_ff <= 32'h0;
        end else if (!mon_en || !sm_nonidle[g]) begin
          dwell_ff <= 32'h0;
        end else if (dwell_ff != TIMEOUT_CYC) begin
          dwell_ff <= dwell_ff + 32'h1;
        end
      end
      assign hit[g] = mon_en && sm_nonidle[g] && (dwell_ff == TIMEOUT_CYC - 32'h1);
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stuck_reset_req <= 1'b0;
      stuck_irq <= 1'b0;
    end else begin
      stuck_reset_req <= (|hit) && !irq_sel;
      stuck_irq <= (|hit) && irq_sel;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stuck_exclusive: assert property (!(stuck_reset_req && stuck_irq))
    else $error("stuck monitor raised reset and interrupt together");
  a_stuck_needs_en: assert property ((stuck_reset_req || stuck_irq) |-> $past(mon_en))
    else $error("stuck monitor fired while disabled");

endmodule : bsc_stuck_monitor

/* verif/bsc_board_host.sv */
`timescale 1ns/1ps

module bsc_board_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] strap_value,
  input wire logic [7:0] tx_value,
  input wire logic host_early,
  input wire logic managed_ff,
  input wire logic table_init_busy_ff,
  input wire logic eeprom_load_req_ff,
  output logic [15:0] strap_config_pins,
  output logic [7:0] port_tx_enable_straps,
  output logic global_control_reg_init_complete,
  output logic eeprom_load_done
);
  logic seen_busy_ff;
  logic [3:0] wait_cnt_ff;
  logic [3:0] ee_dly_ff;

  // Every strap, reserved ones included, follows strap_value and tx_value as the testbench drives them
  assign strap_config_pins = strap_value;
  assign port_tx_enable_straps = tx_value;
  assign eeprom_load_done = ee_dly_ff[3] & eeprom_load_req_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_busy_ff <= 1'b0;
      wait_cnt_ff <= 4'h0;
      global_control_reg_init_complete <= 1'b0;
    end else begin
      if (table_init_busy_ff) begin
        seen_busy_ff <= 1'b1;
      end
      if (host_early && managed_ff) begin
        global_control_reg_init_complete <= 1'b1;
      end else if (seen_busy_ff && !table_init_busy_ff) begin
        // Host lets table setup finish, then sets init-complete
        if (wait_cnt_ff == 4'h5) begin
          global_control_reg_init_complete <= 1'b1;
        end else begin
          wait_cnt_ff <= wait_cnt_ff + 4'h1;
        end
      end
    end
  end

  // Serial memory answers a few cycles after a load request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ee_dly_ff <= 4'h0;
    end else begin
      ee_dly_ff <= {ee_dly_ff[2:0], eeprom_load_req_ff};
    end
  end
endmodule : bsc_board_host

/* verif/testbench.sv */
`timescale 1ns/1ps

module testbench;
  logic clk, rst, host_early, global_control_reg_init_complete, eeprom_load_done, timeout_irq_sel;
  logic [15:0] strap_value, strap_config_pins;
  logic [7:0] tx_value, port_tx_enable_straps, sm_nonidle, module_type_ff, weighted_random_drop_pct_ff;
  logic [9:0] port_activity, port_power_save_ff, fc_frame_thresh_ff;
  bsc_pkg::bsc_mgmt_t mgmt_mode_ff;
  logic straps_valid_ff, managed_ff, serial_debounce_en_ff, eeprom_load_req_ff, hotswap_en_ff, power_save_en_ff;
  logic timeout_mon_en_ff, timeout_reset_req_ff, timeout_irq_ff, table_init_busy_ff, switch_enable_ff;
  logic vlan_port_based_ff, learn_zero_mac_ff, rsvd_mc_drop_ff, rsvd_mc_to_cpu_ff, ip_mc_en_ff, trunk_en_ff;
  logic mirror_en_ff, flood_ctrl_en_ff, pad_short_ff, std_preamble_ff, strict_prio_ff, stp_forwarding_ff;
  logic learn_en_ff, fe_rmii_mode_ff, uplink_mii_mode_ff, autoneg_fd_fc_ff, irq_en_all_ff, learn_report_en_ff;
  logic stats_en_ff, cpu_full_duplex_fc_ff, heartbeat_en_ff;
  logic [2:0] serial_dev_id_ff;
  logic [15:0] age_time_s_ff;
  logic [10:0] frame_min_ff, frame_max_ff;
  logic [8:0] fe_buf_ff, fe_thresh_ff, uplink_buf_ff, uplink_thresh_ff;
  logic [6:0] cpu_speed_m_ff;
  logic [3:0] cpu_hdr_pad_ff;
  int bad_count, compares;

  bsc_strap_loader #(.TIMEOUT_CYC(20), .TBL_INIT_CYC(8)) dut (
    .clk, .rst, .strap_config_pins, .port_tx_enable_straps, .global_control_reg_init_complete,
    .eeprom_load_done, .port_activity, .sm_nonidle, .timeout_irq_sel, .straps_valid_ff, .mgmt_mode_ff,
    .managed_ff, .serial_debounce_en_ff, .serial_dev_id_ff, .eeprom_load_req_ff, .hotswap_en_ff,
    .module_type_ff, .power_save_en_ff, .port_power_save_ff, .timeout_mon_en_ff, .timeout_reset_req_ff,
    .timeout_irq_ff, .table_init_busy_ff, .switch_enable_ff, .vlan_port_based_ff, .learn_zero_mac_ff,
    .rsvd_mc_drop_ff, .rsvd_mc_to_cpu_ff, .ip_mc_en_ff, .trunk_en_ff, .mirror_en_ff, .age_time_s_ff,
    .fc_frame_thresh_ff, .weighted_random_drop_pct_ff, .flood_ctrl_en_ff, .frame_min_ff, .frame_max_ff,
    .pad_short_ff, .std_preamble_ff, .strict_prio_ff, .stp_forwarding_ff, .learn_en_ff, .fe_rmii_mode_ff,
    .uplink_mii_mode_ff, .autoneg_fd_fc_ff, .fe_buf_ff, .fe_thresh_ff, .uplink_buf_ff, .uplink_thresh_ff,
    .irq_en_all_ff, .learn_report_en_ff, .stats_en_ff, .cpu_speed_m_ff, .cpu_full_duplex_fc_ff,
    .cpu_hdr_pad_ff, .heartbeat_en_ff
  );

  bsc_board_host partner (
    .clk, .rst, .strap_value, .tx_value, .host_early, .managed_ff, .table_init_busy_ff,
    .eeprom_load_req_ff, .strap_config_pins, .port_tx_enable_straps, .global_control_reg_init_complete,
    .eeprom_load_done
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // Reset held four cycles; returns just after the edge where decoded outputs land
  task automatic do_reset(input logic [15:0] s, input logic [7:0] t);
    @(posedge clk);
    strap_value <= s;
    tx_value <= t;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : do_reset

  task automatic t_modes();
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
    logic [15:0] s;
    logic [2:0] em;
    logic mg, par;
    for (int i = 0; i < 6; i++) begin
      em = codes[i][2] ? 3'h7 : codes[i];
      mg = em != 3'h7;
      par = codes[i] < 3'h2;
      s = 16'hE100 | {12'h000, codes[i], 1'b0} | (par ? 16'h00F1 : ((16'(i) << 4) | 16'(i & 1)));
      do_reset(s, 8'h3C);
      chk(straps_valid_ff, 1'h1);
      chk(mgmt_mode_ff, em);
      chk(managed_ff, mg);
      chk({serial_debounce_en_ff, serial_dev_id_ff}, par ? 4'h0 : {s[0], s[6:4]});
      chk(eeprom_load_req_ff, !mg);
      chk({hotswap_en_ff, module_type_ff, power_save_en_ff, timeout_mon_en_ff}, 11'h000);
      chk({rsvd_mc_to_cpu_ff, irq_en_all_ff, learn_report_en_ff, stats_en_ff}, {mg, mg, 2'h0});
      chk({cpu_speed_m_ff, cpu_hdr_pad_ff}, mg ? {7'h64, 4'h8} : 11'h000);
      chk({cpu_full_duplex_fc_ff, heartbeat_en_ff}, {mg, 1'b0});
      chk({switch_enable_ff, table_init_busy_ff}, {!mg, mg});
      @(posedge clk);
      strap_value <= ~s;
      repeat (10) @(posedge clk);
      #1;
      chk({mgmt_mode_ff, serial_dev_id_ff}, {em, par ? 3'h0 : s[6:4]});
      chk(eeprom_load_req_ff, 1'h0);
      chk(switch_enable_ff, !mg);
    end
  endtask : t_modes

  task automatic t_defaults();
    chk({vlan_port_based_ff, learn_zero_mac_ff, rsvd_mc_drop_ff, ip_mc_en_ff, trunk_en_ff, mirror_en_ff}, 6'h28);
    chk(age_time_s_ff, 16'h012C);
    chk({fc_frame_thresh_ff, weighted_random_drop_pct_ff, flood_ctrl_en_ff}, {10'h060, 8'h00, 1'b0});
    chk({frame_min_ff, frame_max_ff, pad_short_ff, std_preamble_ff, strict_prio_ff, stp_forwarding_ff,
         learn_en_ff}, {11'h040, 11'h5F2, 5'h1F});
    chk({fe_rmii_mode_ff, uplink_mii_mode_ff, autoneg_fd_fc_ff, fe_buf_ff, fe_thresh_ff, uplink_buf_ff,
         uplink_thresh_ff}, {3'h7, 9'h060, 9'h030, 9'h180, 9'h0C0});
  endtask : t_defaults

  task automatic t_host_init();
    int n;
    for (int e = 1; e >= 0; e--) begin
      host_early <= e[0];
      do_reset(16'hE1F1, 8'h00);
      for (n = 0; n < 20 && table_init_busy_ff === 1'b1; n++) begin
        chk(switch_enable_ff, 1'h0);
        @(posedge clk);
        #1;
      end
      chk(n, 8);
      for (n = 0; n < 12 && switch_enable_ff !== 1'b1; n++) begin
        @(posedge clk);
        #1;
      end
      chk({switch_enable_ff, n > 3}, {1'b1, !e[0]});
    end
    host_early <= 1'b0;
  endtask : t_host_init

  task automatic t_hotswap();
    do_reset(16'hE38E, 8'hA5);
    chk({hotswap_en_ff, module_type_ff, eeprom_load_req_ff}, {1'b1, 8'hA5, 1'b0});
    do_reset(16'hE18E, 8'hA5);
    chk({hotswap_en_ff, module_type_ff}, 9'h000);
  endtask : t_hotswap

  task automatic t_power_save();
    do_reset(16'hE98E, 8'h00);
    chk({power_save_en_ff, port_power_save_ff}, 11'h400);
    repeat (1005) @(posedge clk);
    #1;
    chk(port_power_save_ff, 10'h3FF);
    @(posedge clk);
    port_activity <= 10'h005;
    repeat (2) @(posedge clk);
    #1;
    chk(port_power_save_ff, 10'h3FA);
    @(posedge clk);
    port_activity <= 10'h000;
  endtask : t_power_save

  task automatic t_stuck();
    int n_rst, n_irq;
    for (int sel = 0; sel < 2; sel++) begin
      do_reset(16'hF18E, 8'h00);
      chk(timeout_mon_en_ff, 1'h1);
      n_rst = 0;
      n_irq = 0;
      @(posedge clk);
      timeout_irq_sel <= sel[0];
      sm_nonidle <= 8'h04;
      repeat (40) begin
        @(posedge clk);
        #1;
        n_rst += timeout_reset_req_ff;
        n_irq += timeout_irq_ff;
      end
      chk({n_rst[3:0], n_irq[3:0]}, {4'(1 - sel), 4'(sel)});
      @(posedge clk);
      sm_nonidle <= 8'h00;
    end
  endtask : t_stuck

  initial begin
    rst = 1'b1;
    strap_value = 16'hE10E;
    tx_value = 8'h00;
    host_early = 1'b0;
    port_activity = 10'h000;
    sm_nonidle = 8'h00;
    timeout_irq_sel = 1'b0;
    bad_count = 0;
    compares = 0;
    t_modes();
    t_defaults();
    t_host_init();
    t_hotswap();
    t_power_save();
    t_stuck();
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results();
  end
endmodule : testbench
